// ===== core/bcce_defs.vh
// Purpose: Constants for the branch/call/clear/watchdog-clear executor
// Assumes: 16-bit instruction words, byte-addressed 21-bit program counter
// Notes: Included by the executor files only
`ifndef BCCE_DEFS_VH
`define BCCE_DEFS_VH

// ------------------------------------------------------------
// Opcode matching
// ------------------------------------------------------------
`define BCCE_ZBR_MASK 16'hFF00
`define BCCE_ZBR_CODE 16'hE000
`define BCCE_CALL_MASK 16'hFE00
`define BCCE_CALL_CODE 16'hEC00
`define BCCE_CALL2_MASK 16'hF000
`define BCCE_CALL2_CODE 16'hF000
`define BCCE_FCLR_MASK 16'hFE00
`define BCCE_FCLR_CODE 16'h6A00
`define BCCE_WDTCLR_CODE 16'h0004

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define BCCE_FAST_BIT 8
`define BCCE_ACCESS_BIT 8
`define BCCE_LIT_MSB 7
`define BCCE_HI_MSB 11

// ------------------------------------------------------------
// Values and offsets
// ------------------------------------------------------------
`define BCCE_PC_STEP 21'h000002
`define BCCE_RET_OFFSET 21'h000004
`define BCCE_CLEAR_VALUE 8'h00
`define BCCE_ACCESS_BANK 4'h0

// ------------------------------------------------------------
// Decoded operation codes
// ------------------------------------------------------------
`define BCCE_OP_OTHER 3'h0
`define BCCE_OP_ZBR 3'h1
`define BCCE_OP_CALL 3'h2
`define BCCE_OP_FCLR 3'h3
`define BCCE_OP_WDTCLR 3'h4

`endif

// ===== core/bcce_decode.v
// Purpose: Classify one instruction word into the handled operations
// Assumes: Word presented by the executor each cycle
// Notes: Pure combinational
`timescale 1ns/1ns
`default_nettype none
`include "bcce_defs.vh"

module bcce_decode
(
  // Instruction in
  input wire [15:0] instrWord,
  // Class out
  output reg [2:0] opClass
);

  always @*
  begin
    if ((instrWord & `BCCE_ZBR_MASK) == `BCCE_ZBR_CODE)
      opClass = `BCCE_OP_ZBR;
    else if ((instrWord & `BCCE_CALL_MASK) == `BCCE_CALL_CODE)
      opClass = `BCCE_OP_CALL;
    else if ((instrWord & `BCCE_FCLR_MASK) == `BCCE_FCLR_CODE)
      opClass = `BCCE_OP_FCLR;
    else if (instrWord == `BCCE_WDTCLR_CODE)
      opClass = `BCCE_OP_WDTCLR;
    else
      opClass = `BCCE_OP_OTHER;
  end

endmodule
`default_nettype wire

// ===== core/bcce_exec.v
// Purpose: Execute zero branch, subroutine call, file clear, watchdog clear
// Assumes: One instruction word per enabled cycle, prefetched in order
// Notes: Other instructions just advance the counter by one word
// How it works
// - Zero set: counter becomes its value plus 2 plus twice displacement.
// - Zero branch opcode is upper byte E0, low byte is displacement.
// - Zero branch is one word; one cycle untaken, two cycles taken.
// - Zero branch changes no status flag.
// - Call pushes its own address plus 4 as the stack top.
// - Fast bit set copies accumulator, flags, bank select to shadows.
// - Call loads 20-bit target into counter bits 20 to 1.
// - Call is two words: EC/ED plus low target, then F plus high.
// - Call takes three cycles; the third does nothing.
// - File clear writes zero, sets zero flag, one cycle.
// - Access bit 0 selects access bank; 1 selects bank-select bank.
// - Watchdog clear zeroes counter and postscaler in one cycle.
// - Watchdog clear sets expiry and sleep-entry status bits.
`timescale 1ns/1ns
`default_nettype none
`include "bcce_defs.vh"

module bcce_exec
#(
  parameter PC_W = 21
)
(
  // Clock and reset
  input wire clk_sys,
  input wire rst_n,
  input wire clkEn,
  // Instruction stream
  input wire [15:0] instrWord,
  input wire instrValid,
  // Core state in
  input wire zeroFlagIn,
  input wire [7:0] accumIn,
  input wire [7:0] statusIn,
  input wire [3:0] bankSelectIn,
  // Program counter and stack
  output reg [PC_W-1:0] programCounter_q,
  output reg [PC_W-1:0] stackTop_q,
  output reg stackPush_q,
  // Shadows
  output reg [7:0] accumulatorShadow_q,
  output reg [7:0] flagRegisterShadow_q,
  output reg [3:0] bankSelectShadow_q,
  // File write
  output reg fileWrite_q,
  output reg [11:0] fileAddr_q,
  output reg [7:0] fileData_q,
  output reg zeroFlagSet_q,
  // Watchdog
  output reg watchdogClear_q,
  output reg watchdogExpiryFlag_q,
  output reg sleepEntryFlag_q,
  // Pipeline status
  output reg flushNop_q,
  output wire busy
);

  // ------------------------------------------------------------
  // State codes and working registers
  // ------------------------------------------------------------
  // One flush state is enough: every redirect drops exactly one word
  localparam ST_RUN = 1'b0;
  localparam ST_NOP = 1'b1;

  reg state_q;
  reg [7:0] callLow_q;
  reg callFast_q;
  reg callWait_q;
  reg [PC_W-1:0] callAddr_q;
  wire [2:0] opClass;
  wire [PC_W-1:0] pcStep;
  wire [PC_W-1:0] branchTarget;
  wire [PC_W-1:0] dispTwice;

  // ------------------------------------------------------------
  // Helper decoding
  // ------------------------------------------------------------
  // Bank part of a file address: the access bank unless the word
  // asks for the bank-select register
  function [11:0] fileAddress;
    input [15:0] word;
    input [3:0] bank;
    begin
      if (word[`BCCE_ACCESS_BIT])
        fileAddress = {bank, word[`BCCE_LIT_MSB:0]};
      else
        fileAddress = {`BCCE_ACCESS_BANK, word[`BCCE_LIT_MSB:0]};
    end
  endfunction

  // ------------------------------------------------------------
  // Instruction decode
  // ------------------------------------------------------------
  bcce_decode bcce_decode_inst
  (
    .instrWord(instrWord),
    .opClass(opClass)
  );

  // ------------------------------------------------------------
  // Next-address arithmetic
  // ------------------------------------------------------------
  // Sign-extended displacement, doubled for word addressing
  assign dispTwice = {{(PC_W-9){instrWord[`BCCE_LIT_MSB]}},
                      instrWord[`BCCE_LIT_MSB:0], 1'b0};
  assign pcStep = programCounter_q + `BCCE_PC_STEP;
  assign branchTarget = pcStep + dispTwice;
  assign busy = (state_q == ST_NOP) || callWait_q;

  // ------------------------------------------------------------
  // Execution
  // ------------------------------------------------------------
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= ST_RUN;
      programCounter_q <= {PC_W{1'b0}};
      stackTop_q <= {PC_W{1'b0}};
      stackPush_q <= 1'b0;
      accumulatorShadow_q <= 8'h00;
      flagRegisterShadow_q <= 8'h00;
      bankSelectShadow_q <= 4'h0;
      fileWrite_q <= 1'b0;
      fileAddr_q <= 12'h000;
      fileData_q <= 8'h00;
      zeroFlagSet_q <= 1'b0;
      watchdogClear_q <= 1'b0;
      watchdogExpiryFlag_q <= 1'b0;
      sleepEntryFlag_q <= 1'b0;
      flushNop_q <= 1'b0;
      callLow_q <= 8'h00;
      callFast_q <= 1'b0;
      callWait_q <= 1'b0;
      callAddr_q <= {PC_W{1'b0}};
    end
    else if (clkEn)
    begin
      // Low enable holds every register, pulses included
      stackPush_q <= 1'b0;
      fileWrite_q <= 1'b0;
      zeroFlagSet_q <= 1'b0;
      watchdogClear_q <= 1'b0;
      flushNop_q <= 1'b0;
      case (state_q)
        ST_NOP:
        begin
          // Prefetched word is dropped here
          flushNop_q <= 1'b1;
          state_q <= ST_RUN;
        end
        ST_RUN:
        begin
          if (instrValid && callWait_q)
          begin
            // Second call word: only its upper nibble marks it
            if ((instrWord & `BCCE_CALL2_MASK) == `BCCE_CALL2_CODE)
            begin
              stackTop_q <= callAddr_q + `BCCE_RET_OFFSET;
              stackPush_q <= 1'b1;
              if (callFast_q)
              begin
                accumulatorShadow_q <= accumIn;
                flagRegisterShadow_q <= statusIn;
                bankSelectShadow_q <= bankSelectIn;
              end
              programCounter_q <= {instrWord[`BCCE_HI_MSB:0],
                                   callLow_q, 1'b0};
              state_q <= ST_NOP;
            end
            else
              programCounter_q <= pcStep;
            callWait_q <= 1'b0;
          end
          else if (instrValid)
          begin
            case (opClass)
              `BCCE_OP_ZBR:
              begin
                // Flags untouched on either path
                if (zeroFlagIn)
                begin
                  programCounter_q <= branchTarget;
                  state_q <= ST_NOP;
                end
                else
                  programCounter_q <= pcStep;
              end
              `BCCE_OP_CALL:
              begin
                callLow_q <= instrWord[`BCCE_LIT_MSB:0];
                callFast_q <= instrWord[`BCCE_FAST_BIT];
                callAddr_q <= programCounter_q;
                callWait_q <= 1'b1;
                programCounter_q <= pcStep;
              end
              `BCCE_OP_FCLR:
              begin
                fileWrite_q <= 1'b1;
                fileData_q <= `BCCE_CLEAR_VALUE;
                zeroFlagSet_q <= 1'b1;
                fileAddr_q <= fileAddress(instrWord, bankSelectIn);
                programCounter_q <= pcStep;
              end
              `BCCE_OP_WDTCLR:
              begin
                watchdogClear_q <= 1'b1;
                watchdogExpiryFlag_q <= 1'b1;
                sleepEntryFlag_q <= 1'b1;
                programCounter_q <= pcStep;
              end
              default:
                programCounter_q <= pcStep;
            endcase
          end
        end
        default:
          state_q <= ST_RUN;
      endcase
    end
  end

endmodule
`default_nettype wire

// ===== tb/bcce_exec_properties.sv
// Purpose: Port-level properties of the executor
// Assumes: accumIn held steady across a call
// Notes: Bound onto every bcce_exec
`timescale 1ns/1ns
`default_nettype none
module bcce_exec_props
#(
  parameter PC_W = 21
)
(
  // Clock and inputs
  input wire clk_sys,
  input wire rst_n,
  input wire clkEn,
  input wire instrValid,
  input wire [15:0] instrWord,
  input wire zeroFlagIn,
  input wire [7:0] accumIn,
  input wire [3:0] bankSelectIn,
  input wire busy,
  // Results
  input wire [PC_W-1:0] programCounter_q,
  input wire [PC_W-1:0] stackTop_q,
  input wire stackPush_q,
  input wire [7:0] accumulatorShadow_q,
  input wire fileWrite_q,
  input wire [11:0] fileAddr_q,
  input wire [7:0] fileData_q,
  input wire zeroFlagSet_q,
  input wire watchdogClear_q,
  input wire watchdogExpiryFlag_q,
  input wire sleepEntryFlag_q,
  input wire flushNop_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  localparam [PC_W-1:0] STEP_ONE = 2;
  localparam [PC_W-1:0] STEP_CALL = 4;
  wire take = clkEn && instrValid && !busy;
  wire isZbr = take && instrWord[15:8] == 8'hE0;
  wire isCall = take && instrWord[15:9] == 7'h76;
  wire word2 = clkEn && instrValid && instrWord[15:12] == 4'hF;
  wire notWord2 = clkEn && instrValid && instrWord[15:12] != 4'hF;
  // Sums kept at counter width so wrap matches the hardware
  reg [PC_W-1:0] zbrDest_q;
  reg [PC_W-1:0] pcStep_q;
  reg [PC_W-1:0] retAddr_q;
  always @(posedge clk_sys)
  begin
    zbrDest_q <= programCounter_q + STEP_ONE +
      {{(PC_W-9){instrWord[7]}}, instrWord[7:0], 1'b0};
    pcStep_q <= programCounter_q + STEP_ONE;
    retAddr_q <= programCounter_q + STEP_CALL;
  end
  sequence s_call;
    isCall ##1 word2;
  endsequence
  sequence s_abort;
    isCall ##1 notWord2;
  endsequence
  // ----
  // Properties
  // ----
  a_zbr_taken: assert property (
    isZbr && zeroFlagIn |=> programCounter_q == zbrDest_q ##1 flushNop_q)
    else $error("taken branch wrong");
  a_zbr_skip: assert property (
    isZbr && !zeroFlagIn |=> programCounter_q == pcStep_q ##1 !flushNop_q)
    else $error("untaken branch wrong");
  a_zbr_flags: assert property (
    isZbr |=> !zeroFlagSet_q && !fileWrite_q && !watchdogClear_q)
    else $error("branch touched flags");
  a_call_seq: assert property (
    s_call |=> stackPush_q && stackTop_q == $past(retAddr_q) &&
    programCounter_q == {$past(instrWord[11:0]), $past(instrWord[7:0], 2),
    1'b0} ##1 flushNop_q)
    else $error("call wrong");
  a_call_abort: assert property (
    s_abort |=> !stackPush_q && programCounter_q == pcStep_q)
    else $error("aborted call wrong");
  a_fast_shadow: assert property (
    isCall && instrWord[8] ##1 word2 |=>
    accumulatorShadow_q == $past(accumIn))
    else $error("fast shadow wrong");
  a_slow_keep: assert property (
    isCall && !instrWord[8] ##1 word2 |=> $stable(accumulatorShadow_q))
    else $error("shadow changed");
  a_fclr_write: assert property (
    take && instrWord[15:9] == 7'h35 |=> fileWrite_q && zeroFlagSet_q &&
    fileData_q == 8'h00 && fileAddr_q == {$past(instrWord[8]) ?
    $past(bankSelectIn) : 4'h0, $past(instrWord[7:0])})
    else $error("clear wrong");
  a_watchdog_clear: assert property (
    take && instrWord == 16'h0004 |=> watchdogClear_q &&
    watchdogExpiryFlag_q && sleepEntryFlag_q)
    else $error("watchdog clear wrong");
endmodule
bind bcce_exec bcce_exec_props #(.PC_W(PC_W)) bcce_exec_props_inst (
  .clk_sys, .rst_n, .clkEn, .instrValid, .instrWord, .zeroFlagIn,
  .accumIn, .bankSelectIn, .busy, .programCounter_q, .stackTop_q,
  .stackPush_q, .accumulatorShadow_q, .fileWrite_q, .fileAddr_q,
  .fileData_q, .zeroFlagSet_q, .watchdogClear_q, .watchdogExpiryFlag_q,
  .sleepEntryFlag_q, .flushNop_q);
`default_nettype wire

// ===== tb/bcce_exec_tb_top.sv
// Purpose: Random self-checking run of the executor
// Assumes: Idle and flush cycles leave the counter alone
// Notes: Accumulator held steady across each call
`timescale 1ns/1ns
`default_nettype none
module bcce_exec_tb_top;
  reg clk_sys = 1'b0;
  reg rst_n = 1'b0;
  reg clkEn = 1'b1;
  reg instrValid = 1'b0;
  reg zeroFlagIn = 1'b0;
  reg [15:0] instrWord = 16'h0000;
  reg [7:0] accumIn = 8'h00;
  reg [7:0] statusIn = 8'h00;
  reg [3:0] bankSelectIn = 4'h0;
  wire [20:0] programCounter_q, stackTop_q;
  wire [7:0] accumulatorShadow_q, flagRegisterShadow_q, fileData_q;
  wire [3:0] bankSelectShadow_q;
  wire [11:0] fileAddr_q;
  wire stackPush_q, fileWrite_q, zeroFlagSet_q, watchdogClear_q;
  wire watchdogExpiryFlag_q, sleepEntryFlag_q, flushNop_q, busy;
  integer failures = 0, compares = 0, seed = 76, i, op;
  reg [20:0] pcExp;
  reg [19:0] k;
  reg [7:0] shA, shS, d;
  reg [3:0] shB;
  reg z, f;
  bcce_exec #(.PC_W(21)) bcce_exec_inst (.clk_sys, .rst_n, .clkEn,
    .instrWord, .instrValid, .zeroFlagIn, .accumIn, .statusIn,
    .bankSelectIn, .programCounter_q, .stackTop_q, .stackPush_q,
    .accumulatorShadow_q, .flagRegisterShadow_q, .bankSelectShadow_q,
    .fileWrite_q, .fileAddr_q, .fileData_q, .zeroFlagSet_q,
    .watchdogClear_q, .watchdogExpiryFlag_q, .sleepEntryFlag_q,
    .flushNop_q, .busy);
  initial forever #4 clk_sys = ~clk_sys;
  task end_sim;
    if (failures == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    compares = compares + 1;
    if (g !== e)
    begin
      failures = failures + 1;
      $display("ERROR %s expected %h got %h", nm, e, g);
    end
  endtask
  // Keeps valid high between the two words of a call
  task put(input [15:0] w, input last);
    instrWord <= w;
    instrValid <= 1'b1;
    @(posedge clk_sys);
    if (last)
      instrValid <= 1'b0;
  endtask
  function [20:0] zbrDest(input [20:0] pc, input [7:0] n, input t);
    zbrDest = t ? pc + 21'h2 + {{12{n[7]}}, n, 1'b0} : pc + 21'h2;
  endfunction
  initial
  begin
    #100000;
    failures = failures + 1;
    end_sim;
  end
  initial
  begin
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    {pcExp, shA, shS, shB} = 0;
    #1;
    chk("pcRst", 0, programCounter_q);
    chk("expiryRst", 0, watchdogExpiryFlag_q);
    chk("sleepRst", 0, sleepEntryFlag_q);
    for (i = 0; i < 400; i = i + 1)
    begin
      @(posedge clk_sys);
      op = (i < 8) ? i % 4 : (i < 10) ? i - 4 : {$random(seed)} % 6;
      d = (i == 0) ? 8'h80 : (i == 4) ? 8'h7F : $random(seed);
      z = (i == 0 || i == 4) ? 1'b1 : $random(seed);
      f = $random(seed);
      k = $random(seed);
      zeroFlagIn <= z;
      accumIn <= $random(seed);
      statusIn <= $random(seed);
      bankSelectIn <= $random(seed);
      case (op)
        0:
        begin
          // A taken branch keeps its word up through the flush cycle
          put({8'hE0, d}, !z);
          #1;
          pcExp = zbrDest(pcExp, d, z);
          chk("pc", pcExp, programCounter_q);
          chk("zset", 0, zeroFlagSet_q);
          chk("busy", z, busy);
          @(posedge clk_sys);
          instrValid <= 1'b0;
          #1;
          chk("flush", z, flushNop_q);
          chk("pcHold", pcExp, programCounter_q);
        end
        1:
        begin
          put({7'h76, f, k[7:0]}, 1'b0);
          put({4'hF, k[19:8]}, 1'b1);
          #1;
          pcExp = pcExp + 21'h4;
          chk("top", pcExp, stackTop_q);
          chk("push", 1, stackPush_q);
          chk("busy", 1, busy);
          pcExp = {k, 1'b0};
          chk("pc", pcExp, programCounter_q);
          if (f)
            {shA, shS, shB} = {accumIn, statusIn, bankSelectIn};
          chk("shA", shA, accumulatorShadow_q);
          chk("shS", shS, flagRegisterShadow_q);
          chk("shB", shB, bankSelectShadow_q);
          @(posedge clk_sys);
          #1;
          chk("flush", 1, flushNop_q);
          chk("busyEnd", 0, busy);
        end
        2:
        begin
          put({7'h35, f, d}, 1'b1);
          #1;
          pcExp = pcExp + 21'h2;
          chk("pc", pcExp, programCounter_q);
          chk("write", 1, fileWrite_q);
          chk("data", 0, fileData_q);
          chk("zset", 1, zeroFlagSet_q);
          chk("addr", {f ? bankSelectIn : 4'h0, d}, fileAddr_q);
        end
        3:
        begin
          put(16'h0004, 1'b1);
          #1;
          pcExp = pcExp + 21'h2;
          chk("pc", pcExp, programCounter_q);
          chk("dogClear", 1, watchdogClear_q);
          chk("expiry", 1, watchdogExpiryFlag_q);
          chk("sleep", 1, sleepEntryFlag_q);
        end
        4:
        begin
          // Word offered with the enable low must leave no trace
          clkEn <= 1'b0;
          put(16'h0004, 1'b1);
          clkEn <= 1'b1;
          #1;
          chk("frozenPc", pcExp, programCounter_q);
          chk("frozenClr", 0, watchdogClear_q);
        end
        default:
        begin
          // Second word without the F prefix cancels the call
          put({7'h76, f, k[7:0]}, 1'b0);
          put(16'h0004, 1'b1);
          #1;
          pcExp = pcExp + 21'h4;
          chk("abortPc", pcExp, programCounter_q);
          chk("abortPush", 0, stackPush_q);
          chk("abortClr", 0, watchdogClear_q);
          chk("abortBusy", 0, busy);
          chk("abortShA", shA, accumulatorShadow_q);
        end
      endcase
    end
    end_sim;
  end
endmodule
`default_nettype wire
